//--- rtl/msl_link_map.svh
/*
 * Holds the numeric map of the link slave: command codes, bit counts,
 * upstream frame layout, divider codes, reset values and timing figures.
 * Assumes it is included by bare name wherever one of these numbers is needed.
 */
`ifndef MSL_LINK_MAP_SVH
`define MSL_LINK_MAP_SVH

// ****************************************************************
// Downstream frame shape
// ****************************************************************
`define MSL_CMD_BITS        6'h0f
`define MSL_DATA_BITS       6'h1f
`define MSL_BITCNT_MAX      6'h3f
`define MSL_PAYLOAD_W       30
`define MSL_CMD_LSB         16
`define MSL_CODE_MSB        21
`define MSL_CDATA_LSB       22

// ****************************************************************
// Command codes
// ****************************************************************
`define MSL_CMD_START       6'h22
`define MSL_CMD_CONFIG      6'h18
`define MSL_CMD_RD1         6'h03
`define MSL_CMD_RD2         6'h05
`define MSL_CMD_RD_STATUS   6'h06
`define MSL_CMD_RD4         6'h09
`define MSL_CMD_RD5         6'h0a
`define MSL_CMD_RD6         6'h0c
`define MSL_CMD_RD7         6'h2d
`define MSL_CMD_RD8         6'h2e

// ****************************************************************
// Config byte fields and reset values
// ****************************************************************
`define MSL_CFG_DIV_MSB     1
`define MSL_CFG_ACT_EN_BIT  2
`define MSL_DIV_RESET       2'h2
`define MSL_DIV_16          7'h0f
`define MSL_DIV_32          7'h1f
`define MSL_DIV_64          7'h3f
`define MSL_DIV_128         7'h7f

// ****************************************************************
// Status byte fields
// ****************************************************************
`define MSL_ST_OUTPUTS_DISABLED_BIT_BIT  0
`define MSL_ST_FAULT_BIT    1
`define MSL_ST_LEN_ERR_BIT  2
`define MSL_STATUS_BLK      2'h0

// ****************************************************************
// Upstream frame
// ****************************************************************
`define MSL_UP_W            16
`define MSL_UP_STOP         2'h3
`define MSL_UP_LAST_BIT     4'hf
`define MSL_SEQ_LAST        2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define MSL_CLK_MHZ         100
`define MSL_ACT_TIMEOUT_US  142

`endif

//--- rtl/msl_link_pkg.sv
/*
 * Holds the types shared by the link slave files.
 * Assumes the map header is included where numbers are needed.
 */
package msl_link_pkg;

   typedef enum logic [1:0] {
      MSL_UP_IDLE,
      MSL_UP_SEND,
      MSL_UP_GAP
   } msl_up_state_t;

endpackage : msl_link_pkg

//--- rtl/msl_pair_buffer.sv
/*
 * Two-entry buffer with valid and ready on both sides and a flush.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module msl_pair_buffer #(
   parameter int W = 16
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_flush,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);

   logic [W-1:0] mem_ff [2];
   logic         wr_ptr_ff;
   logic         rd_ptr_ff;
   logic [1:0]   cnt_ff;
   wire          push = i_in_valid & o_in_ready;
   wire          pop  = o_out_valid & i_out_ready;

   assign o_in_ready  = (cnt_ff != 2'h2);
   assign o_out_valid = (cnt_ff != 2'h0);
   assign o_out_data  = mem_ff[rd_ptr_ff];

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= i_in_data;
      end
   end

   // Flush drops every queued word, a push in the same cycle included
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= 2'h0;
      end else if (i_flush) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= 2'h0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff ^ push;
         rd_ptr_ff <= rd_ptr_ff ^ pop;
         cnt_ff    <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : msl_pair_buffer

`default_nettype wire

//--- rtl/msl_link_slave.sv
/*
 * Slave end of a serial microsecond link with an activity watch.
 * Assumes the link clock runs free, pins are asynchronous to i_core_clk,
 * the link clock is below 40 MHz and the core clock is 100 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
`include "msl_link_map.svh"

module msl_link_slave
   import msl_link_pkg::*;
#(
   parameter int P_ACT_TIMEOUT_CYC = `MSL_ACT_TIMEOUT_US * `MSL_CLK_MHZ
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_link_clk,
   input  wire logic        i_link_data,
   input  wire logic        i_link_sel_n,
   input  wire logic        i_low_batt_en,
   input  wire logic [31:0] i_read_block_data,
   output logic [5:0]       o_read_block_sel,
   output logic [7:0]       o_ctrl_byte0,
   output logic [7:0]       o_ctrl_byte1,
   output logic [7:0]       o_ctrl_byte2,
   output logic [5:0]       o_ctrl_byte3,
   output logic             o_drivers_enable,
   output logic             o_protected_enable,
   output logic             o_outputs_disabled,
   output logic             o_activity_fault_flag,
   output logic             o_frame_length_error_flag,
   output logic             o_activity_watch_enable,
   output logic             o_reg_clear_strobe,
   output logic [3:0]       o_reg_clear_addr,
   output logic [7:0]       o_reg_clear_mask,
   output logic             o_up_data,
   output logic             o_up_data_oe
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic is_read_cmd(input logic [5:0] code);
      is_read_cmd = (code == `MSL_CMD_RD1) | (code == `MSL_CMD_RD2) |
                    (code == `MSL_CMD_RD_STATUS) | (code == `MSL_CMD_RD4) |
                    (code == `MSL_CMD_RD5) | (code == `MSL_CMD_RD6) |
                    (code == `MSL_CMD_RD7) | (code == `MSL_CMD_RD8);
   endfunction : is_read_cmd

   function automatic logic [6:0] div_last(input logic [1:0] sel);
      unique case (sel)
         2'h0: div_last = `MSL_DIV_16;
         2'h1: div_last = `MSL_DIV_32;
         2'h2: div_last = `MSL_DIV_64;
         2'h3: div_last = `MSL_DIV_128;
      endcase
   endfunction : div_last

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic cl_s1_ff, cl_s2_ff, cl_s3_ff;
   logic di_s1_ff, di_s2_ff;
   logic en_s1_ff, en_s2_ff, en_s3_ff;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {cl_s1_ff, cl_s2_ff, cl_s3_ff} <= 3'h0;
         {di_s1_ff, di_s2_ff}           <= 2'h0;
         {en_s1_ff, en_s2_ff, en_s3_ff} <= 3'h7;
      end else begin
         {cl_s1_ff, cl_s2_ff, cl_s3_ff} <= {i_link_clk, cl_s1_ff, cl_s2_ff};
         {di_s1_ff, di_s2_ff}           <= {i_link_data, di_s1_ff};
         {en_s1_ff, en_s2_ff, en_s3_ff} <= {i_link_sel_n, en_s1_ff, en_s2_ff};
      end
   end

   wire cl_fall   = cl_s3_ff & ~cl_s2_ff;
   wire cl_rise   = ~cl_s3_ff & cl_s2_ff;
   wire sel_act   = ~en_s2_ff;
   wire frame_end = ~en_s3_ff & en_s2_ff;
   wire take_bit  = cl_fall & sel_act;

   // ****************************************************************
   // Downstream receiver
   // ****************************************************************
   logic [5:0]                bitcnt_ff;
   logic                      selbit_ff;
   logic [`MSL_PAYLOAD_W-1:0] pay_ff;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bitcnt_ff <= 6'h00;
         selbit_ff <= 1'b0;
         pay_ff    <= '0;
      end else if (frame_end) begin
         bitcnt_ff <= 6'h00;
      end else if (take_bit) begin
         if (bitcnt_ff == 6'h00) begin
            selbit_ff <= di_s2_ff;
         end else begin
            pay_ff <= {di_s2_ff, pay_ff[`MSL_PAYLOAD_W-1:1]};
         end
         if (bitcnt_ff != `MSL_BITCNT_MAX) begin
            bitcnt_ff <= bitcnt_ff + 6'h01;
         end
      end
   end

   wire       cmd_ok   = frame_end & selbit_ff & (bitcnt_ff == `MSL_CMD_BITS);
   wire       data_ok  = frame_end & ~selbit_ff & (bitcnt_ff == `MSL_DATA_BITS);
   wire       len_err  = frame_end & ~cmd_ok & ~data_ok;
   wire [5:0] cmd_code = pay_ff[`MSL_CODE_MSB:`MSL_CMD_LSB];
   wire [7:0] cmd_data = pay_ff[`MSL_PAYLOAD_W-1:`MSL_CDATA_LSB];
   wire       do_start = cmd_ok & (cmd_code == `MSL_CMD_START);
   wire       do_cfg   = cmd_ok & (cmd_code == `MSL_CMD_CONFIG);
   wire       do_read  = cmd_ok & is_read_cmd(cmd_code);

   // ****************************************************************
   // Control bytes and configuration
   // ****************************************************************
   logic [1:0] div_sel_ff;

   // Executed the cycle after the frame ends, well inside 16 link periods
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ctrl_byte0            <= 8'h00;
         o_ctrl_byte1            <= 8'h00;
         o_ctrl_byte2            <= 8'h00;
         o_ctrl_byte3            <= 6'h00;
         div_sel_ff              <= `MSL_DIV_RESET;
         o_activity_watch_enable <= 1'b1;
      end else begin
         if (data_ok) begin
            {o_ctrl_byte3, o_ctrl_byte2, o_ctrl_byte1, o_ctrl_byte0} <= pay_ff;
         end
         if (do_cfg) begin
            div_sel_ff              <= cmd_data[`MSL_CFG_DIV_MSB:0];
            o_activity_watch_enable <= cmd_data[`MSL_CFG_ACT_EN_BIT];
         end
      end
   end

   // ****************************************************************
   // Activity watch
   // ****************************************************************
   logic [23:0] act_tmr_ff;
   logic        watch_run_ff;
   logic        arm_ff;
   logic        clr_fault, clr_len;

   wire timeout   = watch_run_ff & o_activity_watch_enable &
                    (act_tmr_ff >= P_ACT_TIMEOUT_CYC[23:0]);
   wire start_ok  = do_start & ~o_activity_fault_flag;
   wire nxt_fault = timeout | (o_activity_fault_flag & ~clr_fault);
   wire nxt_len   = len_err | (o_frame_length_error_flag & ~clr_len);

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         act_tmr_ff                <= 24'h00_0000;
         watch_run_ff              <= 1'b0;
         arm_ff                    <= 1'b0;
         o_outputs_disabled        <= 1'b1;
         o_activity_fault_flag     <= 1'b0;
         o_frame_length_error_flag <= 1'b0;
      end else begin
         o_activity_fault_flag     <= nxt_fault;
         o_frame_length_error_flag <= nxt_len;
         if (timeout) begin
            watch_run_ff       <= 1'b0;
            arm_ff             <= 1'b0;
            o_outputs_disabled <= 1'b1;
         end else if (start_ok) begin
            watch_run_ff <= 1'b1;
            arm_ff       <= 1'b1;
            act_tmr_ff   <= 24'h00_0000;
         end else if (data_ok) begin
            act_tmr_ff <= 24'h00_0000;
            if (arm_ff) begin
               o_outputs_disabled <= 1'b0;
               arm_ff             <= 1'b0;
            end
         end else if (watch_run_ff & o_activity_watch_enable) begin
            act_tmr_ff <= act_tmr_ff + 24'h00_0001;
         end
      end
   end

   // No reset request leaves this block on a timeout
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_drivers_enable   <= 1'b0;
         o_protected_enable <= 1'b0;
      end else begin
         o_drivers_enable   <= ~o_outputs_disabled;
         o_protected_enable <= ~o_outputs_disabled | i_low_batt_en;
      end
   end

   // ****************************************************************
   // Read sequencer
   // ****************************************************************
   logic        seq_run_ff;
   logic [1:0]  seq_idx_ff;
   logic [1:0]  seq_blk_ff;
   logic        seq_stat_ff;
   logic        buf_in_ready;
   logic        buf_out_valid;
   logic [15:0] buf_out_data;
   logic        up_pop;

   wire [7:0]  status_byte = {5'h00, o_frame_length_error_flag,
                              o_activity_fault_flag, o_outputs_disabled};
   wire [7:0]  blk_byte    = i_read_block_data[{seq_idx_ff, 3'h0} +: 8];
   wire [7:0]  seq_byte    = (seq_stat_ff & (seq_idx_ff == 2'h0)) ? status_byte : blk_byte;
   wire [3:0]  seq_addr    = {seq_blk_ff, seq_idx_ff};
   wire        seq_par     = ~(^{seq_addr, seq_byte});
   wire [15:0] seq_word    = {`MSL_UP_STOP, seq_par, seq_byte, seq_addr, 1'b0};
   wire        seq_push    = seq_run_ff & buf_in_ready;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seq_run_ff       <= 1'b0;
         seq_idx_ff       <= 2'h0;
         seq_blk_ff       <= 2'h0;
         seq_stat_ff      <= 1'b0;
         o_read_block_sel <= 6'h00;
      end else if (do_read) begin
         seq_run_ff       <= 1'b1;
         seq_idx_ff       <= 2'h0;
         seq_stat_ff      <= (cmd_code == `MSL_CMD_RD_STATUS);
         seq_blk_ff       <= (cmd_code == `MSL_CMD_RD_STATUS) ? `MSL_STATUS_BLK :
                             cmd_code[1:0];
         o_read_block_sel <= cmd_code;
      end else if (seq_push) begin
         seq_idx_ff <= seq_idx_ff + 2'h1;
         if (seq_idx_ff == `MSL_SEQ_LAST) begin
            seq_run_ff <= 1'b0;
         end
      end
   end

   // Full buffer stalls the sequencer; a new read drops queued old words
   msl_pair_buffer #(
      .W (`MSL_UP_W)
   ) u_up_buf (
      .i_core_clk  (i_core_clk),
      .i_rst_n     (i_rst_n),
      .i_flush     (do_read),
      .i_in_valid  (seq_push),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (seq_word),
      .o_out_valid (buf_out_valid),
      .i_out_ready (up_pop),
      .o_out_data  (buf_out_data)
   );

   // ****************************************************************
   // Upstream bit clock and serialiser
   // ****************************************************************
   logic [6:0]    div_cnt_ff;
   logic          bit_tick_ff;
   msl_up_state_t up_st_ff;
   logic [15:0]   up_sr_ff;
   logic [3:0]    up_bit_ff;

   wire div_wrap = cl_rise & (div_cnt_ff >= div_last(div_sel_ff));

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_cnt_ff  <= 7'h00;
         bit_tick_ff <= 1'b0;
      end else begin
         bit_tick_ff <= div_wrap;
         if (div_wrap) begin
            div_cnt_ff <= 7'h00;
         end else if (cl_rise) begin
            div_cnt_ff <= div_cnt_ff + 7'h01;
         end
      end
   end

   assign up_pop = bit_tick_ff & buf_out_valid & (up_st_ff != MSL_UP_SEND);
   assign clr_fault = up_pop & (buf_out_data[4:1] == {`MSL_STATUS_BLK, 2'h0}) &
                      buf_out_data[5 + `MSL_ST_FAULT_BIT];
   assign clr_len   = up_pop & (buf_out_data[4:1] == {`MSL_STATUS_BLK, 2'h0}) &
                      buf_out_data[5 + `MSL_ST_LEN_ERR_BIT];

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         up_st_ff           <= MSL_UP_IDLE;
         up_sr_ff           <= 16'hffff;
         up_bit_ff          <= 4'h0;
         o_up_data          <= 1'b1;
         o_up_data_oe       <= 1'b0;
         o_reg_clear_strobe <= 1'b0;
         o_reg_clear_addr   <= 4'h0;
         o_reg_clear_mask   <= 8'h00;
      end else begin
         o_reg_clear_strobe <= up_pop;
         if (up_pop) begin
            o_reg_clear_addr <= buf_out_data[4:1];
            o_reg_clear_mask <= buf_out_data[12:5];
         end
         if (bit_tick_ff) begin
            unique case (up_st_ff)
               MSL_UP_IDLE, MSL_UP_GAP: begin
                  if (buf_out_valid) begin
                     up_st_ff     <= MSL_UP_SEND;
                     up_sr_ff     <= buf_out_data;
                     up_bit_ff    <= 4'h0;
                     o_up_data    <= buf_out_data[0];
                     o_up_data_oe <= 1'b1;
                  end else begin
                     up_st_ff     <= MSL_UP_IDLE;
                     o_up_data_oe <= 1'b0;
                  end
               end
               MSL_UP_SEND: begin
                  if (up_bit_ff == `MSL_UP_LAST_BIT) begin
                     up_st_ff     <= MSL_UP_GAP;
                     o_up_data    <= 1'b1;
                     o_up_data_oe <= 1'b0;
                  end else begin
                     up_bit_ff    <= up_bit_ff + 4'h1;
                     o_up_data    <= up_sr_ff[up_bit_ff + 4'h1];
                  end
               end
            endcase
         end
      end
   end

endmodule : msl_link_slave

`default_nettype wire

//--- tb/msl_link_checker.sv
/* Concurrent checks on the link slave top ports.
   Assumes binding into msl_link_slave and one core clock domain. */
`timescale 1ns/1ps
`default_nettype none

module msl_link_checker #(
   parameter int P_ACT_TIMEOUT_CYC = 14200
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_low_batt_en,
   input  wire logic o_outputs_disabled,
   input  wire logic o_activity_fault_flag,
   input  wire logic o_frame_length_error_flag,
   input  wire logic o_drivers_enable,
   input  wire logic o_protected_enable,
   input  wire logic o_reg_clear_strobe,
   input  wire logic o_up_data,
   input  wire logic o_up_data_oe
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   // ****************
   // Port relations
   // ****************
   // Strobe and start bit leave on the same edge as the enable
   sequence s_up_start; (!o_up_data && o_reg_clear_strobe) ##1 !o_reg_clear_strobe; endsequence
   property p_up_start; $rose(o_up_data_oe) |-> s_up_start; endproperty
   a_up_start: assert property (p_up_start) else $error("bad upstream start");
   property p_oe_hold; $rose(o_up_data_oe) |-> o_up_data_oe [*8]; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("upstream frame cut short");
   property p_stop; $fell(o_up_data_oe) |-> $past(o_up_data); endproperty
   a_stop: assert property (p_stop) else $error("last stop bit not high");
   property p_len_fall; $fell(o_frame_length_error_flag) |-> o_up_data_oe; endproperty
   a_len_fall: assert property (p_len_fall) else $error("length flag lost");
   property p_drv; o_outputs_disabled |=> !o_drivers_enable; endproperty
   a_drv: assert property (p_drv) else $error("drivers on while disabled");
   property p_prot; $past(i_low_batt_en) && $past(i_rst_n) |-> o_protected_enable; endproperty
   a_prot: assert property (p_prot) else $error("protected group dropped");
   property p_od_fall; $fell(o_outputs_disabled) |-> !o_activity_fault_flag; endproperty
   a_od_fall: assert property (p_od_fall) else $error("enabled with fault set");
   property p_fault_od; $rose(o_activity_fault_flag) |-> ##[0:2] o_outputs_disabled; endproperty
   a_fault_od: assert property (p_fault_od) else $error("fault left outputs on");
endmodule : msl_link_checker

bind msl_link_slave msl_link_checker #(.P_ACT_TIMEOUT_CYC(P_ACT_TIMEOUT_CYC)) u_chk (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_low_batt_en(i_low_batt_en),
   .o_outputs_disabled(o_outputs_disabled), .o_activity_fault_flag(o_activity_fault_flag),
   .o_frame_length_error_flag(o_frame_length_error_flag), .o_up_data(o_up_data),
   .o_drivers_enable(o_drivers_enable), .o_protected_enable(o_protected_enable),
   .o_reg_clear_strobe(o_reg_clear_strobe), .o_up_data_oe(o_up_data_oe));
`default_nettype wire

//--- tb/msl_ctrl_model.sv
/* Link controller model: free-running link clock, select and data.
   Assumes the bench hands frames LSB first with their bit count. */
`timescale 1ns/1ps
`default_nettype none

module msl_ctrl_model (
   output logic o_link_clk,
   output logic o_link_data,
   output logic o_link_sel_n
);
   // ****************
   // Link driving
   // ****************
   // 20 MHz, never stopped: the upstream divider runs from it
   initial begin
      o_link_clk   = 1'b0;
      o_link_sel_n = 1'b1;
      o_link_data  = 1'b1;
      #2;
      forever #25 o_link_clk = ~o_link_clk;
   end

   task automatic send_frame(input logic [30:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge o_link_clk);
         o_link_sel_n <= 1'b0;
         o_link_data  <= bits[i];
      end
      @(posedge o_link_clk);
      o_link_sel_n <= 1'b1;
      // Deselected data must not look like a held bit
      o_link_data  <= ~o_link_data;
      repeat (3) @(posedge o_link_clk);
   endtask : send_frame
endmodule : msl_ctrl_model
`default_nettype wire

//--- tb/msl_link_slave_tb_top.sv
/* Bench for the link slave: frames go out through the controller model,
   flags, control bytes and upstream frames are compared.
   Assumes the design, the map header and the controller model are compiled. */
`timescale 1ns/1ps
`default_nettype none
`include "msl_link_map.svh"

module msl_link_slave_tb_top;
   localparam int          P_TO = 400;
   localparam logic [23:0] P_HI = 24'ha5_3cc3;
   logic        i_core_clk, i_rst_n, lb;
   logic [31:0] blk;
   logic [5:0]  sel, b3;
   logic [7:0]  b0, b1, b2;
   logic        od, flt, len, awe, drv, prot, up, oe;
   logic [3:0]  ca;
   logic [7:0]  cm;
   wire         lclk, ldat, lsel_n, up_pin;
   int          fail_count, check_count;

   assign blk    = {P_HI, 2'h2, sel};
   // External pull-up holds the released line high
   assign up_pin = oe ? up : 1'b1;

   msl_ctrl_model u_ctl (.o_link_clk(lclk), .o_link_data(ldat), .o_link_sel_n(lsel_n));
   msl_link_slave #(.P_ACT_TIMEOUT_CYC(P_TO)) dut (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_link_clk(lclk), .i_link_data(ldat),
      .i_link_sel_n(lsel_n), .i_low_batt_en(lb), .i_read_block_data(blk),
      .o_read_block_sel(sel), .o_ctrl_byte0(b0), .o_ctrl_byte1(b1), .o_ctrl_byte2(b2),
      .o_ctrl_byte3(b3), .o_drivers_enable(drv), .o_protected_enable(prot),
      .o_outputs_disabled(od), .o_activity_fault_flag(flt),
      .o_frame_length_error_flag(len), .o_activity_watch_enable(awe),
      .o_reg_clear_strobe(), .o_reg_clear_addr(ca), .o_reg_clear_mask(cm),
      .o_up_data(up), .o_up_data_oe(oe));

   // ****************
   // Tasks
   // ****************
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cmd(input logic [5:0] code, input logic [7:0] arg);
      u_ctl.send_frame({16'h0000, arg, code, 1'b1}, 15);
      repeat (65) @(negedge i_core_clk);
   endtask : cmd

   task automatic dat(input logic [29:0] val);
      u_ctl.send_frame({val, 1'b0}, 31);
      repeat (65) @(negedge i_core_clk);
   endtask : dat

   task automatic wait_oe(input int lim);
      int n;
      n = 0;
      while (oe !== 1'b1 && n < lim) begin
         @(negedge i_core_clk);
         n++;
      end
      if (oe !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t no upstream frame", $time);
         print_verdict;
      end
   endtask : wait_oe

   task automatic read_blk(input logic [5:0] code, input logic [7:0] f0, input int bit_ns);
      logic [31:0] e;
      logic [15:0] x;
      logic [3:0]  a;
      e = {P_HI, f0};
      // No settle wait here: a fast divider may start the reply at once
      u_ctl.send_frame({16'h0000, 8'h00, code, 1'b1}, 15);
      for (int k = 0; k < 4; k++) begin
         a = {(code == `MSL_CMD_RD_STATUS) ? 2'h0 : code[1:0], k[1:0]};
         x = {2'h3, ~^{a, e[8*k+:8]}, e[8*k+:8], a, 1'b0};
         wait_oe((k == 0) ? 10000 : bit_ns / 10 + 4);
         #(bit_ns / 2);
         for (int i = 0; i < 16; i++) begin
            chk(up_pin, x[i]);
            #(bit_ns);
         end
         chk(oe, 1'b0);
      end
   endtask : read_blk

   // ****************
   // Sequence
   // ****************
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   initial begin
      #900_000;
      fail_count++;
      $display("[ERR] %0t run too long", $time);
      print_verdict;
   end

   initial begin
      i_rst_n = 1'b0;
      lb = 1'b1;
      fail_count = 0;
      check_count = 0;
      repeat (10) @(negedge i_core_clk);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_core_clk);
      chk({od, awe, flt, len, oe}, 5'h18);
      $display("test reset done");
      dat(30'h1234_5678);
      chk({b3, b2, b1, b0, od}, 31'h2468_acf1);
      u_ctl.send_frame({30'h0abc_def0, 1'b0}, 30);
      repeat (65) @(negedge i_core_clk);
      chk({b3, b2, b1, b0, len}, 31'h2468_acf1);
      u_ctl.send_frame({16'h0000, 8'h00, `MSL_CMD_START, 1'b1}, 14);
      dat(30'h0000_0000);
      chk({b0, od}, 9'h001);
      $display("test downstream done");
      read_blk(`MSL_CMD_RD_STATUS, 8'h05, 3200);
      // Last frame popped is index 3 of the status block
      chk({len, ca, cm}, 13'h03a5);
      cmd(`MSL_CMD_CONFIG, 8'h04);
      read_blk(`MSL_CMD_RD1, {2'h2, `MSL_CMD_RD1}, 800);
      $display("test upstream done");
      cmd(`MSL_CMD_START, 8'h00);
      dat(30'h0000_0000);
      chk({od, drv, prot}, 3'h3);
      repeat (P_TO + 20) @(negedge i_core_clk);
      chk({flt, od, drv, prot}, 4'hd);
      lb = 1'b0;
      repeat (2) @(negedge i_core_clk);
      chk(prot, 1'b0);
      cmd(`MSL_CMD_START, 8'h00);
      dat(30'h0000_0000);
      chk(od, 1'b1);
      // Reading the fault flag clears it, so START is honoured again
      read_blk(`MSL_CMD_RD_STATUS, 8'h03, 800);
      cmd(`MSL_CMD_START, 8'h00);
      dat(30'h0000_0000);
      chk({flt, od, drv}, 3'h1);
      cmd(`MSL_CMD_CONFIG, 8'h00);
      repeat (P_TO + 20) @(negedge i_core_clk);
      chk({awe, flt, od}, 3'h0);
      $display("test watch done");
      print_verdict;
   end
endmodule : msl_link_slave_tb_top
`default_nettype wire
